// ==== serial_node_model.sv ====
/*
  Far-side node: shift register on the mode 0 clock, async sender.
  Expects the resolved data wire and the shift clock pin of the port.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_node_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       shift_clk_i,
  input  wire logic       line_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_byte_i,
  input  wire logic       send_i,
  input  wire logic [7:0] send_byte_i,
  input  wire logic       send_ninth_i,
  input  wire logic       async_i,
  output logic            data_o,
  output logic            data_oe_o,
  output logic            busy_o,
  output logic [7:0]      capture_o,
  output logic [3:0]      pulses_o
);
  logic        prev_clk;
  logic        ld;
  logic [7:0]  sh;
  logic [2:0]  nbit;
  logic [10:0] frame;
  int          cnt;
  // async idle is a driven mark level
  assign data_o    = ld ? sh[0] : (busy_o ? frame[0] : 1'b1);
  assign data_oe_o = ld | async_i;
  always_ff @(posedge core_clk_i)
  begin
    prev_clk <= shift_clk_i;
    if (srst_i)
    begin
      ld <= 1'b0;
      busy_o <= 1'b0;
      pulses_o <= 4'h0;
      capture_o <= 8'h00;
    end
    else
    begin
      // ==========================================================
      // shift register, data taken and moved on clock fall
      if (prev_clk && !shift_clk_i)
      begin
        capture_o <= {line_i, capture_o[7:1]};
        pulses_o <= pulses_o + 4'h1;
        sh <= sh >> 1;
        nbit <= nbit + 3'h1;
        if (nbit == 3'h7)
          ld <= 1'b0;
      end
      if (load_i)
      begin
        ld <= 1'b1;
        sh <= load_byte_i;
        nbit <= 3'h0;
      end
      // ==========================================================
      // async sender: start, d0..d7, ninth, stop
      if (send_i)
      begin
        busy_o <= 1'b1;
        frame <= {1'b1, send_ninth_i, send_byte_i, 1'b0};
        cnt <= 0;
      end
      else if (busy_o && cnt == BIT_CLKS * 11 - 1)
        busy_o <= 1'b0;
      else if (busy_o)
      begin
        cnt <= cnt + 1;
        if (cnt % BIT_CLKS == BIT_CLKS - 1)
          frame <= {1'b1, frame[10:1]};
      end
    end
  end
endmodule : serial_node_model
`default_nettype wire

// ==== tb.sv ====
/*
  Self-checking bench for the serial port with a far-side node.
  Needs uart_pkg, the design, the node model and the pin checker.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import uart_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] rdat;
  logic        wt, rxd_o, rxd_oe, txd_o, txd_oe, line;
  logic        tovf = 1'b0, ext_oe = 1'b1, pat = 1'b0;
  logic        p_ld = 1'b0, p_send = 1'b0, p_nin = 1'b0, p_async = 1'b0;
  logic [7:0]  p_byte = 8'h00, p_sbyte = 8'h00, p_cap, v, a, m, d;
  logic        p_d, p_oe, p_busy, mp, nin, ex;
  logic [3:0]  p_pul, pul0;
  logic [23:0] ctab [5] = '{24'h56fc57, 24'hf1faf3, 24'h56ff57,
                            24'h56ffff, 24'h0000a5};
  logic [7:0]  rtab [5] = '{OFS_ADDR, OFS_MASK, OFS_RELOAD, OFS_CONTROL,
                            8'h00};
  int          err_total = 0, num_checks = 0, cyc = 0, n;
  // released line shows a toggling level
  assign line = rxd_oe ? rxd_o : (p_oe ? p_d : pat);
  always #2.5 clk = ~clk;
  uart_serial_port uut (.core_clk_i(clk), .srst_i(srst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .timer_ovf_i(tovf), .ext_oe_i(ext_oe),
    .rxd_i(line), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd_o),
    .txd_oe_o(txd_oe));
  serial_node_model node (.core_clk_i(clk), .srst_i(srst),
    .shift_clk_i(txd_o), .line_i(line), .load_i(p_ld), .load_byte_i(p_byte),
    .send_i(p_send), .send_byte_i(p_sbyte), .send_ninth_i(p_nin),
    .async_i(p_async), .data_o(p_d), .data_oe_o(p_oe), .busy_o(p_busy),
    .capture_o(p_cap), .pulses_o(p_pul));
  // ==========================================================
  // helpers
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk8
  task automatic chk1(input string s, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %b seen %b", s, e, g);
    end
  endtask : chk1
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [7:0] dt, output logic [7:0] q);
    int k;
    @(posedge clk);
    adr <= ad;
    wd <= {24'h0, dt};
    rd <= ~w;
    wr <= w;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wt !== 1'b0 && k < 64);
    if (k == 64) err_total++;
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic poll(input int b);
    int k;
    k = 0;
    v = 8'h00;
    while (v[b] !== 1'b1 && k < 200)
    begin
      bus(1'b0, OFS_CONTROL, 8'h00, v);
      k++;
    end
  endtask : poll
  function automatic logic hit(input logic [7:0] d, a, m);
    logic [7:0] b;
    b = a | m;
    return (((d ^ a) & m) == 8'h00) || (((d ^ b) & b) == 8'h00);
  endfunction : hit
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge clk)
  begin
    pat <= ~pat;
    tovf <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================
  // tests
  initial
  begin
    void'($urandom(8523));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, rtab[i], 8'h00, v);
      chk8("reset value", 8'h00, v);
    end
    $display("test reset done");
    bus(1'b1, OFS_RELOAD, 8'hff, v);
    bus(1'b1, OFS_BAUD_CTRL, 8'h16, v);
    a = 8'($urandom);
    bus(1'b1, OFS_ADDR, a, v);
    be <= 4'h0;
    bus(1'b1, OFS_ADDR, ~a, v);
    be <= 4'h1;
    bus(1'b0, OFS_ADDR, 8'h00, v);
    chk8("station address", a, v);
    bus(1'b1, OFS_IFACE, 8'h01, v);
    ext_oe <= 1'b0;
    repeat (3) @(posedge clk);
    chk1("tx drive low", 1'b0, txd_oe);
    ext_oe <= 1'b1;
    repeat (3) @(posedge clk);
    chk1("tx drive high", 1'b1, txd_oe);
    bus(1'b1, OFS_IFACE, 8'h00, v);
    $display("test registers done");
    d = 8'($urandom);
    pul0 = p_pul;
    bus(1'b1, OFS_BUFFER, d, v);
    poll(BIT_TX_DONE);
    chk1("tx done", 1'b1, v[BIT_TX_DONE]);
    chk8("shifted byte", d, p_cap);
    chk8("clock pulses", 8'h08, {4'h0, 4'(p_pul - pul0)});
    chk1("data idle", 1'b1, rxd_o & rxd_oe);
    d = 8'($urandom);
    p_byte <= d;
    p_ld <= 1'b1;
    @(posedge clk);
    p_ld <= 1'b0;
    bus(1'b1, OFS_CONTROL, 8'h30, v);
    poll(BIT_RX_DONE);
    chk1("rx done", 1'b1, v[BIT_RX_DONE]);
    bus(1'b0, OFS_BUFFER, 8'h00, v);
    chk8("received byte", d, v);
    $display("test shift mode done");
    p_async <= 1'b1;
    bus(1'b1, OFS_POWER, 8'h80, v);
    for (int i = 0; i < 14; i++)
    begin
      {a, m, d} = (i < 5) ? ctab[i] : 24'($urandom);
      mp = (i % 5 != 4);
      nin = (i % 7 != 6);
      bus(1'b1, OFS_ADDR, a, v);
      bus(1'b1, OFS_MASK, m, v);
      bus(1'b1, OFS_CONTROL, {1'b1, i[0], mp, 5'h10}, v);
      p_sbyte <= d;
      p_nin <= nin;
      p_send <= 1'b1;
      @(posedge clk);
      p_send <= 1'b0;
      @(posedge clk);
      n = 0;
      while (p_busy && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      repeat (24) @(posedge clk);
      bus(1'b0, OFS_CONTROL, 8'h00, v);
      ex = !mp || (nin && hit(d, a, m));
      chk1("address accept", ex, v[BIT_RX_DONE]);
      if (ex)
      begin
        bus(1'b0, OFS_BUFFER, 8'h00, v);
        chk8("frame byte", d, v);
      end
    end
    $display("test address match done");
    close_out();
  end
endmodule : tb
`default_nettype wire

// ==== uart_addr_match.sv ====
/*
  Given and broadcast address comparison for multiprocessor frames.
  Assumes address and mask come straight from their registers.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_addr_match
(
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] mask_i,
  output logic            match_o
);
  logic [7:0] bcast;
  logic       given_hit;
  logic       bcast_hit;

  // ==========================================================
  // compare, zero bits are don't care
  always_comb
  begin
    bcast     = addr_i | mask_i;
    given_hit = ((data_i ^ addr_i) & mask_i) == 8'h00;
    bcast_hit = (data_i & bcast) == bcast;
    match_o   = given_hit | bcast_hit;
  end
endmodule : uart_addr_match
`default_nettype wire

// ==== uart_brg.sv ====
/*
  Internal baud generator: 8-bit auto-reload counter with optional /6.
  Assumes reload and control come from registers in the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_brg
  import uart_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       run_i,
  input  wire logic       speed_i,
  input  wire logic [7:0] reload_i,
  output logic            ovf_o
);
  logic [2:0] pre;
  logic [2:0] next_pre;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       step;

  // ==========================================================
  // prescaler and reload counter
  always_comb
  begin
    step     = run_i & (speed_i | (pre == BRG_PRE_MAX));
    next_pre = pre;
    next_cnt = cnt;
    if (!run_i)
      next_pre = 3'h0;
    else if (!speed_i)
      next_pre = (pre == BRG_PRE_MAX) ? 3'h0 : pre + 3'h1;
    if (step)
      next_cnt = (cnt == 8'hff) ? reload_i : cnt + 8'h01;
    ovf_o = step & (cnt == 8'hff);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      pre <= 3'h0;
      cnt <= 8'h00;
    end
    else
    begin
      pre <= next_pre;
      cnt <= next_cnt;
    end
  end
endmodule : uart_brg
`default_nettype wire

// ==== uart_pkg.sv ====
/*
  Constants, register indices and state types of the serial port.
  Assumes a 200 MHz core clock and word-indexed Avalon-MM access.
*/
package uart_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] OFS_CONTROL   = 8'h98;
  localparam logic [7:0] OFS_BUFFER    = 8'h99;
  localparam logic [7:0] OFS_ADDR      = 8'ha9;
  localparam logic [7:0] OFS_MASK      = 8'hb9;
  localparam logic [7:0] OFS_RELOAD    = 8'h91;
  localparam logic [7:0] OFS_BAUD_CTRL = 8'h9b;
  localparam logic [7:0] OFS_POWER     = 8'h87;
  localparam logic [7:0] OFS_IFACE     = 8'hc9;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  // ==========================================================
  // serial_control_reg fields
  localparam int BIT_MODE_HIGH = 7;
  localparam int BIT_MODE_LOW  = 6;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH  = 3;
  localparam int BIT_RX_NINTH  = 2;
  localparam int BIT_TX_DONE   = 1;
  localparam int BIT_RX_DONE   = 0;
  // baud_control_reg, power_control_reg, interface_config_reg fields
  localparam int BIT_BRG_RUN   = 4;
  localparam int BIT_TX_SRC    = 3;
  localparam int BIT_RX_SRC    = 2;
  localparam int BIT_SPEED     = 1;
  localparam int BIT_SHIFT_SRC = 0;
  localparam int BIT_DOUBLE    = 7;
  localparam int BIT_ODE0      = 0;
  localparam int BIT_ODE1      = 1;
  // ==========================================================
  // timing counts
  localparam int         BRG_PRESCALE  = 6;
  localparam logic [2:0] BRG_PRE_MAX   = 3'(BRG_PRESCALE - 1);
  localparam int         M0_FIXED_DIV  = 6;
  localparam logic [2:0] M0_FIXED_MAX  = 3'(M0_FIXED_DIV / 2 - 1);
  localparam int         M0_VAR_TICKS  = 16;
  localparam logic [2:0] M0_VAR_MAX    = 3'(M0_VAR_TICKS / 2 - 1);
  localparam logic [3:0] SAMPLE_POINT  = 4'h7;
  localparam logic [3:0] TICK_LAST     = 4'hf;
  localparam logic [3:0] FRAME_BITS_8  = 4'ha;
  localparam logic [3:0] FRAME_BITS_9  = 4'hb;
  localparam logic [3:0] M0_LAST_BIT   = 4'h7;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_FIXED = 2'b10,
    MODE_UART9 = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ASYNC = 2'b01,
    ST_SHIFT = 2'b10
  } eng_state_t;
endpackage : uart_pkg

// ==== uart_port_monitor.sv ====
/*
  Pin and bus checker for the serial port top.
  Bound to uart_serial_port; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_port_chk (
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        ext_oe_i,
  input wire logic        rxd_o,
  input wire logic        rxd_oe_o,
  input wire logic        txd_o,
  input wire logic        txd_oe_o
);
  wire req = avs_read_i | avs_write_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ==========================================================
  // bus handshake
  sequence s_req_start;
    $rose(req) && avs_waitrequest_o;
  endsequence
  sequence s_granted;
    !avs_waitrequest_o;
  endsequence
  a_wait_once:
    assert property (s_req_start |=> s_granted)
      else $error("bus answer not after one wait cycle");
  a_wait_rearm:
    assert property (req && !avs_waitrequest_o ##1 req |-> avs_waitrequest_o)
      else $error("new request got no wait cycle");
  a_idle_nowait:
    assert property (!req |-> !avs_waitrequest_o)
      else $error("waitrequest without request");
  a_rdata_hold:
    assert property (!avs_read_i && !$past(avs_read_i)
                     |-> $stable(avs_readdata_o))
      else $error("read data moved without read");
  a_upper_zero:
    assert property (avs_readdata_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
  // ==========================================================
  // pins
  a_reset_vals:
    assert property (disable iff (1'b0) srst_i |=> avs_readdata_o == 32'h0
                     && txd_o && rxd_o && !rxd_oe_o && !txd_oe_o)
      else $error("pins or read data wrong in reset");
  a_txd_oe_gate:
    assert property (ext_oe_i && !srst_i |=> txd_oe_o)
      else $error("tx pin not driven with output enable high");
  a_data_steady:
    assert property ($fell(txd_o) |-> $stable(rxd_o))
      else $error("data pin changed at shift clock fall");
endmodule : uart_port_chk

bind uart_serial_port uart_port_chk u_chk (
  .core_clk_i, .srst_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .ext_oe_i, .rxd_o, .rxd_oe_o, .txd_o, .txd_oe_o
);
`default_nettype wire

// ==== uart_serial_port.sv ====
/*
  Serial port: register file on Avalon-MM, async modes 1..3, shift mode 0,
  baud selection and multiprocessor address recognition.
  Assumes pin inputs and the timer overflow pulse are synchronous.
*/
// Decided for this implementation: the Avalon-MM interface to the registers.
// Functional notes
// - multiproc_enable turns on address recognition
// - rx_done_flag only for matching address frames
// - mode 1 uses stop bit as ninth
// - multiproc_enable ignored in mode 0
// - given address is masked station address
// - broadcast is address OR mask, zeros ignored
// - accept on given or broadcast match
// - address and mask reset to zero
// - two mode bits select four modes
// - timer in modes 1,3; generator 0,1,3
// - timer overflow clocks baud, double doubles
// - generator 8-bit reload, optional divide by 6
// - mode 0 half duplex, eight clocks, LSB first
// - buffer write starts mode 0 transmit
// - mode 0 receive after enable, flag clear
// - mode 0 clock fixed /6 or generator
// - outputs gated by external output enable
// - mode 2 baud is clock/32 or /16
// - separate receive and transmit baud sources
`timescale 1ns/10ps
`default_nettype none
module uart_serial_port
  import uart_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        timer_ovf_i,
  input  wire logic        ext_oe_i,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_o,
  output logic             txd_o,
  output logic             txd_oe_o
);
  // ==========================================================
  // register file state
  logic [7:0] ctrl, addr, mask, reload, baud_ctrl, power, iface, rx_buf;
  logic [7:0] next_ctrl, next_addr, next_mask, next_reload;
  logic [7:0] next_baud_ctrl, next_power, next_iface, next_rx_buf;
  logic       ack, next_ack;
  logic [31:0] next_rdata;
  logic       wr_go, tx_start;
  mode_t      mode;
  logic       dbl, mp_on;
  // engine signals
  eng_state_t tx_st, next_tx_st, rx_st, next_rx_st;
  logic [3:0] tcnt, next_tcnt, tbit, next_tbit;
  logic [3:0] rcnt, next_rcnt, rbit, next_rbit;
  logic [10:0] tsh, next_tsh;
  logic [9:0] rsh, next_rsh;
  logic       tph, next_tph, rph, next_rph;
  logic       rx_prev, next_rx_prev;
  logic       tx_done, rx_done, rx_ninth;
  logic [7:0] rx_data;
  logic       match, ninth, last_rx;
  logic [7:0] frame_data;
  logic [2:0] m0cnt, next_m0cnt;
  logic       m0_half, brg_ovf;
  logic       next_txd, next_txd_oe, next_rxd, next_rxd_oe;
  // per-channel baud dividers: 0 tx, 1 rx, 2 mode 0 variable
  logic [2:0] src_ovf, tog, tick;

  assign mode  = mode_t'({ctrl[BIT_MODE_HIGH], ctrl[BIT_MODE_LOW]});
  assign dbl   = power[BIT_DOUBLE];
  assign mp_on = ctrl[BIT_MULTIPROC] & (mode != MODE_SHIFT);
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign wr_go = avs_write_i & ack & avs_byteenable_i[0];
  assign tx_start = wr_go & (avs_address_i == OFS_BUFFER);

  // ==========================================================
  // baud sources and oversampling ticks
  uart_brg u_brg (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      (baud_ctrl[BIT_BRG_RUN]),
    .speed_i    (baud_ctrl[BIT_SPEED]),
    .reload_i   (reload),
    .ovf_o      (brg_ovf)
  );

  always_comb
  begin
    if (mode == MODE_FIXED)
    begin
      src_ovf[0] = 1'b1;
      src_ovf[1] = 1'b1;
    end
    else
    begin
      src_ovf[0] = baud_ctrl[BIT_TX_SRC] ? brg_ovf : timer_ovf_i;
      src_ovf[1] = baud_ctrl[BIT_RX_SRC] ? brg_ovf : timer_ovf_i;
    end
    src_ovf[2] = brg_ovf;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_div
      logic next_tog;
      always_comb
      begin
        next_tog = src_ovf[g] ? ~tog[g] : tog[g];
        tick[g]  = src_ovf[g] & (dbl | tog[g]);
      end
      always_ff @(posedge core_clk_i)
      begin
        if (srst_i)
          tog[g] <= 1'b0;
        else
          tog[g] <= next_tog;
      end
    end
  endgenerate

  // mode 0 half-period tick
  always_comb
  begin
    next_m0cnt = m0cnt;
    m0_half    = 1'b0;
    if (baud_ctrl[BIT_SHIFT_SRC])
    begin
      if (tick[2])
      begin
        m0_half    = (m0cnt == M0_VAR_MAX);
        next_m0cnt = m0_half ? 3'h0 : m0cnt + 3'h1;
      end
    end
    else
    begin
      m0_half    = (m0cnt >= M0_FIXED_MAX);
      next_m0cnt = m0_half ? 3'h0 : m0cnt + 3'h1;
    end
  end

  // ==========================================================
  // transmitter
  always_comb
  begin
    next_tx_st = tx_st;
    next_tcnt  = tcnt;
    next_tbit  = tbit;
    next_tsh   = tsh;
    next_tph   = tph;
    tx_done    = 1'b0;
    unique case (tx_st)
      ST_IDLE:
      begin
        if (tx_start && mode == MODE_SHIFT && rx_st == ST_IDLE)
        begin
          next_tx_st = ST_SHIFT;
          next_tsh   = {3'h7, avs_writedata_i[7:0]};
          next_tbit  = 4'h0;
          next_tph   = 1'b0;
        end
        else if (tx_start && mode != MODE_SHIFT)
        begin
          next_tx_st = ST_ASYNC;
          next_tsh   = {1'b1, ctrl[BIT_TX_NINTH] | (mode == MODE_UART8),
                        avs_writedata_i[7:0], 1'b0};
          next_tbit  = 4'h0;
          next_tcnt  = 4'h0;
        end
      end
      ST_ASYNC:
      begin
        if (tick[0])
        begin
          next_tcnt = tcnt + 4'h1;
          if (tcnt == TICK_LAST)
          begin
            next_tsh  = {1'b1, tsh[10:1]};
            next_tbit = tbit + 4'h1;
            if (tbit == ((mode == MODE_UART8) ? FRAME_BITS_8 : FRAME_BITS_9)
                        - 4'h1)
            begin
              next_tx_st = ST_IDLE;
              tx_done    = 1'b1;
            end
          end
        end
      end
      ST_SHIFT:
      begin
        if (m0_half)
        begin
          next_tph = ~tph;
          if (tph)
          begin
            next_tsh  = {1'b1, tsh[10:1]};
            next_tbit = tbit + 4'h1;
            if (tbit == M0_LAST_BIT)
            begin
              next_tx_st = ST_IDLE;
              tx_done    = 1'b1;
            end
          end
        end
      end
      default:
        next_tx_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      tx_st <= ST_IDLE;
      tcnt  <= 4'h0;
      tbit  <= 4'h0;
      tsh   <= 11'h7ff;
      tph   <= 1'b0;
      m0cnt <= 3'h0;
    end
    else
    begin
      tx_st <= next_tx_st;
      tcnt  <= next_tcnt;
      tbit  <= next_tbit;
      tsh   <= next_tsh;
      tph   <= next_tph;
      m0cnt <= next_m0cnt;
    end
  end

  // ==========================================================
  // receiver
  uart_addr_match u_match (
    .data_i  (frame_data),
    .addr_i  (addr),
    .mask_i  (mask),
    .match_o (match)
  );

  always_comb
  begin
    last_rx    = (rbit == ((mode == MODE_UART8) ? FRAME_BITS_8 : FRAME_BITS_9)
                  - 4'h1);
    ninth      = (mode == MODE_UART8) ? rxd_i : rsh[9];
    frame_data = (mode == MODE_UART8) ? rsh[9:2] : rsh[8:1];
    next_rx_st = rx_st;
    next_rcnt  = rcnt;
    next_rbit  = rbit;
    next_rsh   = rsh;
    next_rph   = rph;
    next_rx_prev = rxd_i;
    rx_done    = 1'b0;
    rx_data    = frame_data;
    rx_ninth   = ninth;
    unique case (rx_st)
      ST_IDLE:
      begin
        if (mode == MODE_SHIFT && ctrl[BIT_RX_ENABLE] &&
            !ctrl[BIT_RX_DONE] && tx_st == ST_IDLE && !tx_start)
        begin
          next_rx_st = ST_SHIFT;
          next_rbit  = 4'h0;
          next_rph   = 1'b0;
        end
        else if (mode != MODE_SHIFT && ctrl[BIT_RX_ENABLE] &&
                 rx_prev && !rxd_i)
        begin
          next_rx_st = ST_ASYNC;
          next_rbit  = 4'h0;
          next_rcnt  = 4'h0;
        end
      end
      ST_ASYNC:
      begin
        if (tick[1])
        begin
          next_rcnt = rcnt + 4'h1;
          if (rcnt == SAMPLE_POINT)
          begin
            next_rbit = rbit + 4'h1;
            next_rsh  = {rxd_i, rsh[9:1]};
            if (rbit == 4'h0 && rxd_i)
              next_rx_st = ST_IDLE;
            else if (last_rx)
            begin
              next_rx_st = ST_IDLE;
              // address frames must match when multiprocessor is on
              rx_done = !ctrl[BIT_RX_DONE] &&
                        (!mp_on || (ninth && match)) &&
                        (mode != MODE_UART8 || rxd_i);
            end
          end
        end
      end
      ST_SHIFT:
      begin
        rx_data  = rsh[9:2];
        rx_ninth = ctrl[BIT_RX_NINTH];
        if (m0_half)
        begin
          next_rph = ~rph;
          if (!rph)
            next_rsh = {rxd_i, rsh[9:1]};
          else
          begin
            next_rbit = rbit + 4'h1;
            if (rbit == M0_LAST_BIT)
            begin
              next_rx_st = ST_IDLE;
              rx_done    = 1'b1;
            end
          end
        end
      end
      default:
        next_rx_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      rx_st   <= ST_IDLE;
      rcnt    <= 4'h0;
      rbit    <= 4'h0;
      rsh     <= 10'h000;
      rph     <= 1'b0;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_st   <= next_rx_st;
      rcnt    <= next_rcnt;
      rbit    <= next_rbit;
      rsh     <= next_rsh;
      rph     <= next_rph;
      rx_prev <= next_rx_prev;
    end
  end

  // ==========================================================
  // registers and bus slave
  always_comb
  begin
    next_ctrl      = ctrl;
    next_addr      = addr;
    next_mask      = mask;
    next_reload    = reload;
    next_baud_ctrl = baud_ctrl;
    next_power     = power;
    next_iface     = iface;
    next_rx_buf    = rx_buf;
    next_ack       = (avs_read_i | avs_write_i) & ~ack;
    next_rdata     = avs_readdata_o;
    if (wr_go)
    begin
      unique case (avs_address_i)
        OFS_CONTROL:   next_ctrl      = avs_writedata_i[7:0];
        OFS_ADDR:      next_addr      = avs_writedata_i[7:0];
        OFS_MASK:      next_mask      = avs_writedata_i[7:0];
        OFS_RELOAD:    next_reload    = avs_writedata_i[7:0];
        OFS_BAUD_CTRL: next_baud_ctrl = avs_writedata_i[7:0];
        OFS_POWER:     next_power     = avs_writedata_i[7:0] & 8'h80;
        OFS_IFACE:     next_iface     = avs_writedata_i[7:0] & 8'h03;
        default:       next_ctrl      = ctrl;
      endcase
    end
    // hardware sets win over a software clear in the same cycle
    if (tx_done)
      next_ctrl[BIT_TX_DONE] = 1'b1;
    if (rx_done)
    begin
      next_ctrl[BIT_RX_DONE]  = 1'b1;
      next_ctrl[BIT_RX_NINTH] = rx_ninth;
      next_rx_buf             = rx_data;
    end
    if (avs_read_i && !ack)
    begin
      unique case (avs_address_i)
        OFS_CONTROL:   next_rdata = {24'h0, ctrl};
        OFS_BUFFER:    next_rdata = {24'h0, rx_buf};
        OFS_ADDR:      next_rdata = {24'h0, addr};
        OFS_MASK:      next_rdata = {24'h0, mask};
        OFS_RELOAD:    next_rdata = {24'h0, reload};
        OFS_BAUD_CTRL: next_rdata = {24'h0, baud_ctrl};
        OFS_POWER:     next_rdata = {24'h0, power};
        OFS_IFACE:     next_rdata = {24'h0, iface};
        default:       next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ctrl           <= RST_BYTE;
      addr           <= RST_BYTE;
      mask           <= RST_BYTE;
      reload         <= RST_BYTE;
      baud_ctrl      <= RST_BYTE;
      power          <= RST_BYTE;
      iface          <= RST_BYTE;
      rx_buf         <= RST_BYTE;
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ctrl           <= next_ctrl;
      addr           <= next_addr;
      mask           <= next_mask;
      reload         <= next_reload;
      baud_ctrl      <= next_baud_ctrl;
      power          <= next_power;
      iface          <= next_iface;
      rx_buf         <= next_rx_buf;
      ack            <= next_ack;
      avs_readdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // pins
  always_comb
  begin
    next_txd    = (tx_st == ST_ASYNC) ? tsh[0] : 1'b1;
    if (mode == MODE_SHIFT)
      next_txd = ~(((tx_st == ST_SHIFT) && tph) ||
                   ((rx_st == ST_SHIFT) && rph));
    next_rxd    = (tx_st == ST_SHIFT) ? tsh[0] : 1'b1;
    next_txd_oe = ~iface[BIT_ODE0] | ext_oe_i;
    next_rxd_oe = (mode == MODE_SHIFT) && (next_rx_st != ST_SHIFT) &&
                  (~iface[BIT_ODE1] | ext_oe_i);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      txd_o    <= 1'b1;
      rxd_o    <= 1'b1;
      txd_oe_o <= 1'b0;
      rxd_oe_o <= 1'b0;
    end
    else
    begin
      txd_o    <= next_txd;
      rxd_o    <= next_rxd;
      txd_oe_o <= next_txd_oe;
      rxd_oe_o <= next_rxd_oe;
    end
  end
endmodule : uart_serial_port
`default_nettype wire
